//--- asc_cfg.svh
// constants for the antenna switch controller: offsets, fields, resets, counts
// assumes a 25 MHz core clock and a plain address/strobe register port
// Function
// RULE_01: epoch strobe from synchronised input rising edge
// RULE_02: epoch output divides epoch clock, ratio programmable
// RULE_03: output enable clear stops divider, output low
// RULE_04: divided epoch holds output high 128 cycles
// RULE_05: internal epoch strobe lasts one cycle
// RULE_06: integrators inhibited 128 cycles per epoch start
// RULE_07: epoch strobe captures 64-bit time counter
// RULE_08: select line0 gets index high bit
// RULE_09: each epoch steps to next masked antenna
// RULE_10: empty mask keeps antenna select static
// RULE_11: select resets to zero, stop keeps value
// RULE_12: epoch end stores selected antenna identifier
// RULE_13: mode zero: own replica, normal reset/latch
// RULE_14: mode one: early/punctual special latch, reset; punctual latch here stays on integration epoch
// RULE_15: mode one: late resets, latches on epoch
// RULE_16: very early/late correlators never change behaviour
// RULE_17: interrupt request possible on every epoch
// RULE_18: system routes epoch input from master output
// RULE_19: sequencer wraps to lowest enabled antenna
// RULE_20: two flip-flop synchroniser before edge detect
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// register port geometry
`define ASC_ADDR_W 8
`define ASC_DATA_W 32

// register byte offsets
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_CORR 8'h04
`define ASC_OFF_TLO 8'h08
`define ASC_OFF_THI 8'h0c

// switch_control_reg fields
`define ASC_RATIO_LSB 0
`define ASC_RATIO_W 10
`define ASC_OUTEN_BIT 10
`define ASC_IRQEN_BIT 11
`define ASC_MASK_LSB 12
`define ASC_ID_LSB 16

// correlator_control_reg fields
`define ASC_MODE_BIT 0

// reset values
`define ASC_RATIO_RST 10'h000
`define ASC_MASK_RST 4'h0
`define ASC_SEL_RST 2'h0

// timing counts in core clock cycles
`define ASC_EPOCH_OUT_CYC 8'h80
`define ASC_INHIBIT_CYC 8'h80

// channel geometry and correlator indices
`define ASC_NUM_CH 4
`define ASC_NUM_CORR 5
`define ASC_C_VE 0
`define ASC_C_E 1
`define ASC_C_P 2
`define ASC_C_L 3
`define ASC_C_VL 4

`endif

//--- asc_pkg.sv
// types for the antenna switch controller
// assumes asc_cfg.svh is on the include path
`include "asc_cfg.svh"

package asc_pkg;

  // per-channel correlator control vector
  typedef logic [`ASC_NUM_CH-1:0][`ASC_NUM_CORR-1:0] asc_corr_t;

  // divider state
  typedef struct packed {
    logic [`ASC_RATIO_W-1:0] cnt;  // epoch ticks seen
    logic pulse;                   // divided epoch pulse
  } asc_div_s;

  // controller state
  typedef struct packed {
    logic sync1;               // first synchroniser stage
    logic sync2;               // second synchroniser stage
    logic sync3;               // edge detect history
    logic strobe;              // internal epoch strobe
    logic [7:0] out_cnt;       // epoch output stretch
    logic epoch_out;           // epoch output pin
    logic [7:0] inh_cnt;       // inhibit stretch
    logic inhibit;             // integrator inhibit
    logic [1:0] sel;           // current antenna index
    logic [1:0] pins;          // encoded select pins
    logic [1:0] switch_id;     // antenna of last period
    logic [`ASC_RATIO_W-1:0] ratio;
    logic out_en;              // output_enable_bit
    logic irq_en;              // interrupt request enable
    logic [3:0] mask;          // sequence_mask
    logic sw_mode;             // correlator_switch_mode
    logic irq;                 // interrupt request pulse
    logic [31:0] time_lo;      // epoch_time_lower
    logic [31:0] time_hi;      // epoch_time_upper
    logic [31:0] rdata;        // read data
    asc_corr_t corr_rst;       // correlator reset pulses
    asc_corr_t corr_lat;       // correlator latch pulses
    logic punct_replica;       // early/late use punctual replica
  } asc_state_s;

endpackage

//--- asc_div.sv
// switch epoch divider: divides epoch ticks by a programmable ratio
// assumes epoch_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "asc_cfg.svh"

module asc_div
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // epoch tick feed
  input wire logic epoch_tick,
  // control
  input wire logic enable,
  input wire logic [`ASC_RATIO_W-1:0] ratio,
  // divided epoch
  output logic div_epoch
);

  asc_pkg::asc_div_s s_q;  // registered state
  asc_pkg::asc_div_s s_d;  // next state

  // next state: count ticks, pulse when count reaches ratio
  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!enable)
    begin
      // disabled divider stands still at zero
      s_d.cnt = '0; // RULE_03
    end
    else if (epoch_tick)
    begin
      // ratio n gives one epoch per n+1 ticks, 1 to 1024
      if (s_q.cnt == ratio)
      begin
        s_d.cnt = '0; // RULE_02
        s_d.pulse = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + `ASC_RATIO_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign div_epoch = s_q.pulse;

endmodule
`default_nettype wire

//--- asc_top.sv
// antenna switch controller: epoch synchroniser, epoch output stretch,
// antenna sequencer, time capture, correlator control and register port
// assumes all inputs synchronous to clk except switch_epoch_in
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "asc_cfg.svh"

module asc_top
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [`ASC_ADDR_W-1:0] reg_addr,
  input wire logic [`ASC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`ASC_DATA_W-1:0] reg_rdata,
  // time base
  input wire logic epoch_tick,
  input wire logic [63:0] time_count,
  // switch epoch pins
  input wire logic switch_epoch_in,
  output logic switch_epoch_out,
  output logic [1:0] antenna_select,
  // channel epochs
  input wire logic [`ASC_NUM_CH-1:0] integration_epoch,
  input wire logic [`ASC_NUM_CH-1:0] loop_epoch,
  // channel controls
  output logic switch_epoch_strobe,
  output logic integrator_inhibit,
  output asc_pkg::asc_corr_t corr_reset,
  output asc_pkg::asc_corr_t corr_latch,
  output logic corr_punct_replica,
  // interrupt request
  output logic switch_epoch_irq
);

  asc_pkg::asc_state_s s_q;  // registered state
  asc_pkg::asc_state_s s_d;  // next state

  logic div_epoch;           // divided epoch pulse
  logic edge_seen;           // rising edge of synchronised input
  asc_pkg::asc_corr_t rst_w; // per-channel reset decode
  asc_pkg::asc_corr_t lat_w; // per-channel latch decode

  // address match, used by both read and write decode
  function automatic logic hit(input logic [`ASC_ADDR_W-1:0] addr,
                               input logic [`ASC_ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  // next higher antenna enabled in mask, wrapping round;
  // an empty mask keeps the current antenna
  function automatic logic [1:0] next_ant(input logic [1:0] cur,
                                          input logic [3:0] mask);
    logic [1:0] idx;
    logic found;
    next_ant = cur;
    found = 1'b0;
    for (int k = 1; k <= 4; k++)
    begin
      idx = cur + k[1:0];
      if (!found && mask[idx])
      begin
        next_ant = idx;
        found = 1'b1;
      end
    end
  endfunction

  // epoch output divider on the epoch tick feed
  asc_div u_div
  (
    .clk(clk),
    .reset(reset),
    .epoch_tick(epoch_tick),
    .enable(s_q.out_en),
    .ratio(s_q.ratio),
    .div_epoch(div_epoch)
  );

  // edge detect looks only at the second and third stages
  assign edge_seen = s_q.sync2 & ~s_q.sync3; // RULE_01

  // per-channel correlator reset and latch decode
  genvar c;
  generate
    for (c = 0; c < `ASC_NUM_CH; c++)
    begin : g_ch
      logic ie;    // integration epoch of this channel
      logic ile;   // integration or loop epoch
      assign ie = integration_epoch[c];
      assign ile = integration_epoch[c] | loop_epoch[c];

      // very early and very late never change behaviour
      assign rst_w[c][`ASC_C_VE] = ile; // RULE_16
      assign lat_w[c][`ASC_C_VE] = ie; // RULE_16
      assign rst_w[c][`ASC_C_VL] = ile; // RULE_16
      assign lat_w[c][`ASC_C_VL] = ie; // RULE_16

      // early: special reset and latch on epoch in switch mode
      assign rst_w[c][`ASC_C_E] = s_q.sw_mode ? (ile & edge_seen) : ile; // RULE_14
      assign lat_w[c][`ASC_C_E] = s_q.sw_mode ? edge_seen : ie; // RULE_14

      // punctual: special reset in switch mode, latch on integration
      assign rst_w[c][`ASC_C_P] = s_q.sw_mode ? (ile & edge_seen) : ile; // RULE_14
      assign lat_w[c][`ASC_C_P] = ie; // RULE_13

      // late: reset and latch on epoch alone in switch mode
      assign rst_w[c][`ASC_C_L] = s_q.sw_mode ? edge_seen : ile; // RULE_15
      assign lat_w[c][`ASC_C_L] = s_q.sw_mode ? edge_seen : ie; // RULE_15
    end
  endgenerate

  // next state of the whole controller
  always_comb
  begin
    s_d = s_q;

    // two-stage synchroniser then history stage
    s_d.sync1 = switch_epoch_in; // RULE_20
    s_d.sync2 = s_q.sync1; // RULE_20
    s_d.sync3 = s_q.sync2;

    // internal strobe: one cycle per detected edge
    s_d.strobe = edge_seen; // RULE_05

    // interrupt request pulses in the same cycle as each strobe when enabled
    s_d.irq = edge_seen & s_q.irq_en; // RULE_17

    // epoch output stretch
    if (!s_q.out_en)
    begin
      // disabled output stays low
      s_d.out_cnt = 8'h00; // RULE_03
    end
    else if (div_epoch)
    begin
      // start a fresh high period
      s_d.out_cnt = `ASC_EPOCH_OUT_CYC; // RULE_04
    end
    else if (s_q.out_cnt != 8'h00)
    begin
      // count the high period down
      s_d.out_cnt = s_q.out_cnt - 8'h01; // RULE_04
    end
    s_d.epoch_out = (s_d.out_cnt != 8'h00); // RULE_04

    // integrator inhibit from each epoch start
    if (edge_seen)
    begin
      // restart the inhibit window
      s_d.inh_cnt = `ASC_INHIBIT_CYC; // RULE_06
    end
    else if (s_q.inh_cnt != 8'h00)
    begin
      // count the inhibit window down
      s_d.inh_cnt = s_q.inh_cnt - 8'h01; // RULE_06
    end
    s_d.inhibit = (s_d.inh_cnt != 8'h00); // RULE_06

    // epoch handling: identifier, sequencer, time capture
    if (edge_seen)
    begin
      // antenna of the period just ended
      s_d.switch_id = s_q.sel; // RULE_12
      // step to next enabled antenna, wrap, or hold on empty mask
      s_d.sel = next_ant(s_q.sel, s_q.mask); // RULE_09 RULE_10 RULE_19
      // capture the measurement time
      s_d.time_lo = time_count[31:0]; // RULE_07
      s_d.time_hi = time_count[63:32]; // RULE_07
    end

    // pin encoding: high index bit on line zero
    s_d.pins[0] = s_d.sel[1]; // RULE_08
    s_d.pins[1] = s_d.sel[0]; // RULE_08

    // correlator control pulses and replica choice
    s_d.corr_rst = rst_w; // RULE_13
    s_d.corr_lat = lat_w; // RULE_13
    s_d.punct_replica = s_q.sw_mode; // RULE_14 RULE_15

    // register writes
    if (reg_write)
    begin
      if (hit(reg_addr, `ASC_OFF_CTRL))
      begin
        // ratio, enables and mask; identifier is read only
        s_d.ratio = reg_wdata[`ASC_RATIO_LSB +: `ASC_RATIO_W];
        s_d.out_en = reg_wdata[`ASC_OUTEN_BIT];
        s_d.irq_en = reg_wdata[`ASC_IRQEN_BIT];
        s_d.mask = reg_wdata[`ASC_MASK_LSB +: 4];
      end
      else if (hit(reg_addr, `ASC_OFF_CORR))
      begin
        // correlator switch mode
        s_d.sw_mode = reg_wdata[`ASC_MODE_BIT];
      end
    end

    // register reads: data valid the cycle after the strobe
    s_d.rdata = '0;
    if (reg_read)
    begin
      if (hit(reg_addr, `ASC_OFF_CTRL))
      begin
        // control fields and the last antenna identifier
        s_d.rdata[`ASC_RATIO_LSB +: `ASC_RATIO_W] = s_q.ratio;
        s_d.rdata[`ASC_OUTEN_BIT] = s_q.out_en;
        s_d.rdata[`ASC_IRQEN_BIT] = s_q.irq_en;
        s_d.rdata[`ASC_MASK_LSB +: 4] = s_q.mask;
        s_d.rdata[`ASC_ID_LSB +: 2] = s_q.switch_id; // RULE_12
      end
      else if (hit(reg_addr, `ASC_OFF_CORR))
      begin
        // switch mode bit
        s_d.rdata[`ASC_MODE_BIT] = s_q.sw_mode;
      end
      else if (hit(reg_addr, `ASC_OFF_TLO))
      begin
        // captured time, low word
        s_d.rdata = s_q.time_lo;
      end
      else if (hit(reg_addr, `ASC_OFF_THI))
      begin
        // captured time, high word
        s_d.rdata = s_q.time_hi;
      end
    end
  end

  // state register; select resets to antenna zero only here,
  // an empty mask later just holds the last antenna
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.ratio <= `ASC_RATIO_RST;
      s_q.mask <= `ASC_MASK_RST;
      s_q.sel <= `ASC_SEL_RST; // RULE_11
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign switch_epoch_out = s_q.epoch_out;
  assign antenna_select = s_q.pins;
  assign switch_epoch_strobe = s_q.strobe;
  assign integrator_inhibit = s_q.inhibit;
  assign corr_reset = s_q.corr_rst;
  assign corr_latch = s_q.corr_lat;
  assign corr_punct_replica = s_q.punct_replica;
  assign switch_epoch_irq = s_q.irq;

endmodule
`default_nettype wire

//--- asc_top_chk.sv
// assertions on asc_top pins: epoch timing, stretches, selects, correlators
// assumes one clock domain and a bind onto asc_top
`timescale 1ns/1ns
`default_nettype none
`include "asc_cfg.svh"

module asc_top_chk
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // epoch pins
  input wire logic switch_epoch_in,
  input wire logic switch_epoch_out,
  input wire logic switch_epoch_strobe,
  input wire logic switch_epoch_irq,
  input wire logic integrator_inhibit,
  input wire logic [1:0] antenna_select,
  // correlator pins
  input wire logic [`ASC_NUM_CH-1:0] integration_epoch,
  input wire logic [`ASC_NUM_CH-1:0] loop_epoch,
  input wire asc_pkg::asc_corr_t corr_reset,
  input wire asc_pkg::asc_corr_t corr_latch,
  input wire logic corr_punct_replica
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [8:0] inh_n_q; // inhibit high cycles, restarts on strobe
  logic [8:0] out_n_q; // epoch output high cycles
  // count how long each stretch stands
  always_ff @(posedge clk)
  begin
    inh_n_q <= (reset || !integrator_inhibit) ? 9'h000 : (switch_epoch_strobe ? 9'h001 : inh_n_q + 9'h001);
    out_n_q <= (reset || !switch_epoch_out) ? 9'h000 : out_n_q + 9'h001;
  end
  property p_sync; $rose(switch_epoch_in) |-> ##3 switch_epoch_strobe; endproperty
  a_sync: assert property (p_sync) else $error("strobe late after input edge");
  property p_src; switch_epoch_strobe |-> $past(switch_epoch_in, 3) && !$past(switch_epoch_in, 4); endproperty
  a_src: assert property (p_src) else $error("strobe without input edge");
  property p_one; switch_epoch_strobe |=> !switch_epoch_strobe; endproperty
  a_one: assert property (p_one) else $error("strobe longer than one cycle");
  property p_inh; switch_epoch_strobe |-> integrator_inhibit; endproperty
  a_inh: assert property (p_inh) else $error("no inhibit at epoch");
  property p_inh_len; $fell(integrator_inhibit) |-> inh_n_q == 9'h080; endproperty
  a_inh_len: assert property (p_inh_len) else $error("inhibit length wrong");
  property p_out_len; $fell(switch_epoch_out) |-> out_n_q >= 9'h080; endproperty
  a_out_len: assert property (p_out_len) else $error("epoch output too short");
  property p_sel; !switch_epoch_strobe |-> $stable(antenna_select); endproperty
  a_sel: assert property (p_sel) else $error("select moved off epoch");
  property p_irq; switch_epoch_irq |-> switch_epoch_strobe; endproperty
  a_irq: assert property (p_irq) else $error("irq without strobe");
  property p_ve; !$past(reset) |-> corr_reset[0][`ASC_C_VE] == $past(integration_epoch[0] | loop_epoch[0])
    && corr_latch[0][`ASC_C_VE] == $past(integration_epoch[0]); endproperty
  a_ve: assert property (p_ve) else $error("very early pulses wrong");
  property p_pl; !$past(reset) |-> corr_latch[3][`ASC_C_P] == $past(integration_epoch[3]); endproperty
  a_pl: assert property (p_pl) else $error("punctual latch wrong");
  property p_m1; corr_punct_replica && $past(corr_punct_replica) |-> corr_latch[0][`ASC_C_E] == switch_epoch_strobe
    && corr_latch[0][`ASC_C_L] == switch_epoch_strobe && corr_reset[0][`ASC_C_L] == switch_epoch_strobe; endproperty
  a_m1: assert property (p_m1) else $error("mode one early or late wrong");
endmodule

bind asc_top asc_top_chk u_chk (.clk, .reset, .switch_epoch_in, .switch_epoch_out, .switch_epoch_strobe,
  .switch_epoch_irq, .integrator_inhibit, .antenna_select, .integration_epoch, .loop_epoch, .corr_reset,
  .corr_latch, .corr_punct_replica);
`default_nettype wire

//--- asc_far.sv
// far side: board trace looping the epoch output back, and the antenna switch
// assumes a single receiver chip acting as its own master
`timescale 1ns/1ns
`default_nettype none

module asc_far
(
  // pins from the controller
  input wire logic switch_epoch_out,
  input wire logic [1:0] antenna_select,
  // pin back to the controller
  output logic switch_epoch_in,
  // antenna the switch connects
  output logic [1:0] antenna_now
);
  // trace skew keeps the edge off the clock edge
  assign #7 switch_epoch_in = switch_epoch_out;
  // switch decode, line zero carries the high bit
  assign antenna_now = {antenna_select[0], antenna_select[1]};
endmodule
`default_nettype wire

//--- tb.sv
// testbench for asc_top: looped epochs, antenna sequence, time capture
// assumes asc_top_chk is bound and asc_far loops the epoch back
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk, reset, reg_write, reg_read, epoch_tick, sei, seo, strobe, inh, rep, irq, irq_exp;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ctrl_w;
  logic [63:0] time_count, cap;
  logic [3:0] ie, le;
  logic [1:0] sel, ant, cur, prv;
  asc_pkg::asc_corr_t c_rst, c_lat;
  logic [31:0] q_rd[$]; // expected read data
  logic [1:0] q_ant[$]; // expected antenna per epoch
  int mismatches, n_compared, eps, gap, per, exp_per, r, i;
  logic rd_pend;
  asc_top uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .epoch_tick,
    .time_count, .switch_epoch_in(sei), .switch_epoch_out(seo), .antenna_select(sel),
    .integration_epoch(ie), .loop_epoch(le), .switch_epoch_strobe(strobe), .integrator_inhibit(inh),
    .corr_reset(c_rst), .corr_latch(c_lat), .corr_punct_replica(rep), .switch_epoch_irq(irq));
  asc_far far (.switch_epoch_out(seo), .antenna_select(sel), .switch_epoch_in(sei), .antenna_now(ant));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // register writes and reads, idle cycle after each
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
  endtask
  // next higher masked antenna, wrapping, or hold
  function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] m);
    logic [1:0] k;
    nxt = c;
    for (int s = 1; s <= 4; s++)
    begin
      k = c + 2'(s);
      if (m[k] && nxt == c)
        nxt = k;
    end
  endfunction
  task automatic wait_eps(input int n);
    int t;
    t = eps + n;
    for (int w = 0; w < 5000 && eps < t; w++)
      @(posedge clk);
    if (eps < t)
      check("epoch wait", 32'h0, 32'h1);
  endtask
  // tick every 160 cycles, free time counter, random channel epochs
  always @(posedge clk)
  begin
    time_count <= time_count + 64'h1;
    gap <= (gap == 159) ? 0 : gap + 1;
    epoch_tick <= (gap == 159);
    ie <= ($urandom % 8 == 0) ? 4'($urandom) : 4'h0;
    le <= ($urandom % 8 == 0) ? 4'($urandom) : 4'h0;
  end
  // compare results against the oldest notes
  always @(posedge clk)
  begin
    if (rd_pend)
      check("rdata", reg_rdata, q_rd.pop_front());
    rd_pend <= reg_read;
    if (per >= 0)
      per++;
    if (strobe === 1'b1)
    begin
      cap = time_count - 64'h1;
      check("antenna", {30'h0, ant}, {30'h0, q_ant.pop_front()});
      check("irq", {31'h0, irq}, {31'h0, irq_exp});
      if (per > 0)
        check("period", 32'(per), 32'(exp_per));
      per = 0;
      eps++;
    end
  end
  initial
  begin
    #(40 * 20000);
    mismatches++;
    close_out;
  end
  initial
  begin
    {reset, reg_write, reg_read, epoch_tick, rd_pend} = 5'h10;
    {reg_addr, reg_wdata, ie, le} = '0;
    time_count = 64'h0000_0001_ffff_fe00;
    {gap, eps, per} = {32'h0, 32'h0, -32'sh1};
    void'($urandom(32'ha8f23599));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("select", {30'h0, sel}, 32'h0);
    rd(8'h00, 32'h0);
    $display("test reset done");
    r = $urandom % 4;
    exp_per = (r + 1) * 160;
    ctrl_w = {16'h0, 4'hb, 1'b1, 1'b1, 10'(r)};
    {cur, irq_exp} = 3'h1;
    for (i = 0; i < 5; i++)
    begin
      prv = cur;
      cur = nxt(cur, 4'hb);
      q_ant.push_back(cur);
    end
    wr(8'h00, ctrl_w);
    wait_eps(5);
    rd(8'h00, ctrl_w | {14'h0, prv, 16'h0});
    rd(8'h08, cap[31:0]);
    rd(8'h0c, cap[63:32]);
    $display("test sequence done");
    ctrl_w = {16'h0, 4'h0, 1'b0, 1'b1, 10'(r)};
    irq_exp = 1'b0;
    per = -1;
    repeat (3) q_ant.push_back(cur);
    wr(8'h00, ctrl_w);
    wr(8'h04, 32'h1);
    wait_eps(3);
    check("replica", {31'h0, rep}, 32'h1);
    rd(8'h00, ctrl_w | {14'h0, cur, 16'h0});
    rd(8'h10, 32'h0);
    $display("test empty mask done");
    // let the running output stretch finish so the disable does not cut it
    while (seo === 1'b1)
      @(posedge clk);
    wr(8'h00, {16'h0, 4'hb, 12'h0});
    repeat (2) @(posedge clk);
    i = 0;
    repeat (700)
    begin
      @(posedge clk);
      i += int'(seo === 1'b1 || strobe === 1'b1);
    end
    check("disabled out", 32'(i), 32'h0);
    check("held select", {30'h0, ant}, {30'h0, cur});
    $display("test disable done");
    close_out;
  end
endmodule
`default_nettype wire
